// file: design/thermal_fan_config_registers.sv
// register bank for overtemperature duration limit, fan pulse counts and pin config
//
// Operation
// RQ1: eight-bit limit, 22.76 ms per step
// RQ2: limit spans 45.52 ms to 5.82 s; code flags after at most 255 steps, and a limit of 0xFF never flags
// RQ3: exceeding limit sets interrupt status bit five
// RQ4: zero limit flags at once on assertion
// RQ5: limit register at 0x7A resets zero
// RQ6: two-bit pulse field per fan
// RQ7: pulses counted equals field value plus one
// RQ8: pulse register resets to 0x55
// RQ9: bit zero selects alert output or input
// RQ10: bits three two pick two-wire threshold
// RQ11: lock bit makes config four read-only
// RQ12: config four reserved bits read zero
// RQ13: config four resets to zero
// RQ14: test registers 0x7E 0x7F read-only zero
// RQ15: host should not write test registers
// RQ16: duration count steps, zero below two steps
// RQ17: fourth fan mask suppresses timer alert
// RQ18: compare count with limit each update
`timescale 1ns/1ps
`include "thermal_fan_defs.svh"
module thermal_fan_config_registers #(
  parameter int unsigned STEP_CYCLES = `STEP_CYCLES
) (
  // register clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       clk_en_i,
  // link side register access, on its own clock
  input  wire logic       link_clk_i,
  input  wire logic       link_valid_i,
  input  wire logic       link_write_i,
  input  wire logic [7:0] link_addr_i,
  input  wire logic [7:0] link_wdata_i,
  // read answer, register clock domain
  output logic [7:0]      rdata_o,
  output logic            rvalid_o,
  // neighbouring registers of the unit
  input  wire logic       config_lock_i,
  input  wire logic       fourth_fan_fault_flag_i,
  input  wire logic       status2_clear_i,
  // overtemperature pin, active low
  input  wire logic       overtemp_signal_n_i,
  // outputs to the rest of the unit
  output logic            overtemp_status_o,
  output logic            overtemp_alert_o,
  output logic [1:0]      tach_pulses_first_o,
  output logic [1:0]      tach_pulses_second_o,
  output logic [1:0]      tach_pulses_third_o,
  output logic [1:0]      tach_pulses_fourth_o,
  output logic            alert_pin_select_o,
  output logic [1:0]      twowire_input_threshold_o,
  output logic [7:0]      overtemp_duration_count_o
);
  overtemp_link_if link ();                     // timer to bank carrier

  logic       tgl_link;                         // request toggle, link domain
  logic       wr_link;                          // request write flag, link domain
  logic [7:0] addr_link;                        // request address, link domain
  logic [7:0] wdata_link;                       // request data, link domain
  logic       tgl_s1_q;                         // first sync stage of toggle
  logic       tgl_s2_q;                         // second sync stage
  logic       tgl_s3_q;                         // delayed, for edge detect
  logic       req_fire;                         // one request arrived
  logic       lock_s1_q;                        // lock bit sync stages
  logic       lock_s2_q;
  logic       mask_s1_q;                        // fourth fan mask sync stages
  logic       mask_s2_q;
  logic [7:0] limit_q;                          // assert_duration_limit
  logic [7:0] pulses_q;                         // pulse counts per fan
  logic [7:0] pincfg_q;                         // pin and threshold config
  logic [7:0] test_one_q;                       // vendor test one, read-only
  logic [7:0] test_two_q;                       // vendor test two, read-only
  logic       status_q;                         // sticky interrupt status bit

  // decode address to a read value
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    case (a)
      `OFS_DURATION_LIMIT:  read_mux = limit_q;
      `OFS_PULSE_SELECT:    read_mux = pulses_q;
      `OFS_PIN_CONFIG:      read_mux = pincfg_q & `MASK_PIN_CONFIG; // see RQ12
      `OFS_VENDOR_TEST_ONE: read_mux = test_one_q;
      `OFS_VENDOR_TEST_TWO: read_mux = test_two_q;
      default:              read_mux = 8'h00;
    endcase
  endfunction

  // link side capture
  reg_serial_port u_port (
    .link_clk_i   (link_clk_i),
    .resetn_i     (resetn_i),
    .link_valid_i (link_valid_i),
    .link_write_i (link_write_i),
    .link_addr_i  (link_addr_i),
    .link_wdata_i (link_wdata_i),
    .req_toggle_o (tgl_link),
    .req_write_o  (wr_link),
    .req_addr_o   (addr_link),
    .req_wdata_o  (wdata_link)
  );

  // overtemperature duration timer
  overtemp_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_timer (
    .ref_clk_i           (ref_clk_i),
    .resetn_i            (resetn_i),
    .clk_en_i            (clk_en_i),
    .overtemp_signal_n_i (overtemp_signal_n_i),
    .link                (link.timer)
  );

  assign link.limit = limit_q;                  // see RQ1 see RQ2

  // toggle synchroniser; data words are stable when the edge is seen
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      tgl_s1_q <= tgl_link;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end

  assign req_fire = clk_en_i & (tgl_s2_q ^ tgl_s3_q);

  // level synchronisers for external bits
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      mask_s1_q <= 1'b0;
      mask_s2_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      lock_s1_q <= config_lock_i;
      lock_s2_q <= lock_s1_q;
      mask_s1_q <= fourth_fan_fault_flag_i;
      mask_s2_q <= mask_s1_q;
    end

  // limit register
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
      limit_q <= `RST_DURATION_LIMIT;           // see RQ5
    else if (req_fire && wr_link && addr_link == `OFS_DURATION_LIMIT)
      limit_q <= wdata_link;                    // see RQ1

  // pulse count register
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
      pulses_q <= `RST_PULSE_SELECT;            // see RQ8
    else if (req_fire && wr_link && addr_link == `OFS_PULSE_SELECT)
      pulses_q <= wdata_link;                   // see RQ6

  // pin config, ignored while locked, reserved bits kept zero
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
      pincfg_q <= `RST_PIN_CONFIG;              // see RQ13
    else if (req_fire && wr_link && addr_link == `OFS_PIN_CONFIG && !lock_s2_q) // see RQ11
      pincfg_q <= wdata_link & `MASK_PIN_CONFIG; // see RQ12

  // test registers: writes never land
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      test_one_q <= `RST_VENDOR_TEST;           // see RQ14
      test_two_q <= `RST_VENDOR_TEST;
    end

  // sticky status bit, set wins over clear
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
      status_q <= 1'b0;
    else if (clk_en_i)
    begin
      if (link.expired)
        status_q <= 1'b1;                       // see RQ3
      else if (status2_clear_i)
        status_q <= 1'b0;
    end

  // read answer one cycle after request
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      rvalid_o <= req_fire & ~wr_link;
      if (req_fire && !wr_link)
        rdata_o <= read_mux(addr_link);
    end

  // registered outputs
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      overtemp_status_o         <= 1'b0;
      overtemp_alert_o          <= 1'b0;
      tach_pulses_first_o       <= 2'h0;
      tach_pulses_second_o      <= 2'h0;
      tach_pulses_third_o       <= 2'h0;
      tach_pulses_fourth_o      <= 2'h0;
      alert_pin_select_o        <= 1'b0;
      twowire_input_threshold_o <= 2'h0;
      overtemp_duration_count_o <= 8'h00;
    end
    else if (clk_en_i)
    begin
      overtemp_status_o         <= status_q;
      overtemp_alert_o          <= status_q & ~mask_s2_q
                                   & pincfg_q[`POS_ALERT_SELECT]; // see RQ17 see RQ9
      tach_pulses_first_o       <= pulses_q[1:0]; // see RQ7
      tach_pulses_second_o      <= pulses_q[3:2];
      tach_pulses_third_o       <= pulses_q[5:4];
      tach_pulses_fourth_o      <= pulses_q[7:6];
      alert_pin_select_o        <= pincfg_q[`POS_ALERT_SELECT]; // see RQ9
      twowire_input_threshold_o <= pincfg_q[`POS_THRESHOLD_LO +: 2]; // see RQ10
      overtemp_duration_count_o <= link.count;
    end
endmodule // thermal_fan_config_registers

// file: design/thermal_fan_defs.svh
// offsets, field positions, reset values and timing counts of the thermal and fan register group
`ifndef THERMAL_FAN_DEFS_SVH
`define THERMAL_FAN_DEFS_SVH
`define OFS_DURATION_LIMIT  8'h7A
`define OFS_PULSE_SELECT    8'h7B
`define OFS_PIN_CONFIG      8'h7D
`define OFS_VENDOR_TEST_ONE 8'h7E
`define OFS_VENDOR_TEST_TWO 8'h7F
`define RST_DURATION_LIMIT  8'h00
`define RST_PULSE_SELECT    8'h55
`define RST_PIN_CONFIG      8'h00
`define RST_VENDOR_TEST     8'h00
`define POS_ALERT_SELECT    0
`define POS_THRESHOLD_LO    2
`define POS_OVERTEMP_FLAG   5
`define MASK_PIN_CONFIG     8'h0D
`define STEP_TIME_US        22760
`define CLK_PERIOD_NS       10
`define STEP_CYCLES         ((`STEP_TIME_US * 1000) / `CLK_PERIOD_NS)
`endif

// file: design/thermal_fan_pkg.sv
// types shared by the thermal and fan register group
package thermal_fan_pkg;
  // two-wire fan input threshold codes
  typedef enum logic [1:0]
  {
    thr_20mv  = 2'h0,
    thr_40mv  = 2'h1,
    thr_80mv  = 2'h2,
    thr_130mv = 2'h3
  } twowire_threshold_t;
  // overtemperature timer states, gray along the usual path
  typedef enum logic [1:0]
  {
    tmr_idle   = 2'h0,
    tmr_timing = 2'h1,
    tmr_hold   = 2'h3
  } timer_state_t;
endpackage

// file: design/overtemp_link_if.sv
// carrier between the overtemperature timer and the register bank
`timescale 1ns/1ps
interface overtemp_link_if;
  logic [7:0] count;  // overtemp_duration_count, in register clock domain
  logic       expired; // one-cycle pulse: count passed the limit, or pin asserted with a zero limit
  logic [7:0] limit;  // assert_duration_limit value
  modport timer (output count, output expired, input limit);
  modport bank  (input count, input expired, output limit);
endinterface // overtemp_link_if

// file: design/overtemp_timer.sv
// measures how long the overtemperature input stays asserted
`timescale 1ns/1ps
`include "thermal_fan_defs.svh"
module overtemp_timer #(
  parameter int unsigned STEP_CYCLES = `STEP_CYCLES
) (
  // clock and reset
  input  wire logic      ref_clk_i,
  input  wire logic      resetn_i,
  input  wire logic      clk_en_i,
  // pin, active low, asynchronous
  input  wire logic      overtemp_signal_n_i,
  // to the register bank
  overtemp_link_if.timer link
);
  logic       sync1_q;                          // first synchroniser stage
  logic       sync2_q;                          // second stage, active high asserted
  logic [31:0] tick_q;                          // cycles within current step
  logic [7:0] count_q;                          // duration count in steps
  logic       fired_q;                          // flag already raised this assertion
  logic       expired_q;                        // pulse to bank
  thermal_fan_pkg::timer_state_t state_q;       // timer state

  // two-flop synchroniser of the pin
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      sync1_q <= ~overtemp_signal_n_i;
      sync2_q <= sync1_q;
    end

  // step counter and duration count, restart on each assertion
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      state_q <= thermal_fan_pkg::tmr_idle;
      tick_q  <= 32'h0;
      count_q <= 8'h00;
    end
    else if (clk_en_i)
    begin
      case (state_q)
        thermal_fan_pkg::tmr_idle:
          if (sync2_q)
          begin
            state_q <= thermal_fan_pkg::tmr_timing;
            tick_q  <= 32'h0;
            count_q <= 8'h00;
          end
        thermal_fan_pkg::tmr_timing:
          if (!sync2_q)
            state_q <= thermal_fan_pkg::tmr_idle;   // count stays readable
          else if (tick_q == STEP_CYCLES - 1)
          begin
            tick_q <= 32'h0;
            if (count_q == 8'hFF)
              state_q <= thermal_fan_pkg::tmr_hold; // saturated
            else
              count_q <= count_q + 8'h01;           // see RQ16
          end
          else
            tick_q <= tick_q + 32'h1;
        thermal_fan_pkg::tmr_hold:
          if (!sync2_q)
            state_q <= thermal_fan_pkg::tmr_idle;
        default:
          state_q <= thermal_fan_pkg::tmr_idle;
      endcase
    end

  // compare on every update; zero limit fires on assertion
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      fired_q   <= 1'b0;
      expired_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      expired_q <= 1'b0;
      if (!sync2_q)
        fired_q <= 1'b0;
      else if (!fired_q && ((link.limit == 8'h00) ||     // see RQ4
               (count_q > link.limit && count_q >= 8'h02))) // see RQ3 see RQ18
      begin
        fired_q   <= 1'b1;
        expired_q <= 1'b1;
      end
    end

  // reported count reads zero until two steps have passed
  assign link.count   = (count_q >= 8'h02) ? count_q : 8'h00; // see RQ16
  assign link.expired = expired_q;
endmodule // overtemp_timer

// file: design/reg_serial_port.sv
// link-clock side byte port: assembles address and data, hands them over by toggle
`timescale 1ns/1ps
module reg_serial_port (
  // link clock domain
  input  wire logic       link_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       link_valid_i,
  input  wire logic       link_write_i,
  input  wire logic [7:0] link_addr_i,
  input  wire logic [7:0] link_wdata_i,
  // to register clock domain
  output logic            req_toggle_o,
  output logic            req_write_o,
  output logic [7:0]      req_addr_o,
  output logic [7:0]      req_wdata_o
);
  // capture a request and flip the toggle; words stay stable until next one
  always_ff @(posedge link_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      req_toggle_o <= 1'b0;
      req_write_o  <= 1'b0;
      req_addr_o   <= 8'h00;
      req_wdata_o  <= 8'h00;
    end
    else if (link_valid_i)
    begin
      req_toggle_o <= ~req_toggle_o;
      req_write_o  <= link_write_i;
      req_addr_o   <= link_addr_i;
      req_wdata_o  <= link_wdata_i;
    end
endmodule // reg_serial_port

// file: testbench/thermal_fan_config_registers_monitor.sv
// checker on the ports of the thermal and fan register bank
`timescale 1ns/1ps
module thermal_fan_config_registers_monitor #(
  parameter int unsigned STEP_CYCLES = 10
) (
  // register clock and reset
  input wire logic       ref_clk_i,
  input wire logic       resetn_i,
  // inputs
  input wire logic       clk_en_i,
  input wire logic       config_lock_i,
  input wire logic       fourth_fan_fault_flag_i,
  input wire logic       status2_clear_i,
  input wire logic       overtemp_signal_n_i,
  // outputs
  input wire logic       rvalid_o,
  input wire logic       overtemp_status_o,
  input wire logic       overtemp_alert_o,
  input wire logic       alert_pin_select_o,
  input wire logic [1:0] twowire_input_threshold_o,
  input wire logic [7:0] overtemp_duration_count_o
);
  logic [7:0] cnt; // short alias of the duration count
  assign cnt = overtemp_duration_count_o;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // read answer is a single pulse
  a_rvalid_one_cycle: assert property (rvalid_o |=> !rvalid_o)
    else $error("read answer held too long");
  // alert needs the pin selected as alert output
  a_alert_needs_sel: assert property (
    !alert_pin_select_o [*2] |-> !overtemp_alert_o)
    else $error("alert with pin not selected");
  // fourth fan mask suppresses the timer alert
  a_alert_masked: assert property (
    fourth_fan_fault_flag_i [*5] |-> !overtemp_alert_o)
    else $error("masked alert raised");
  // status stays set until cleared
  a_status_sticky: assert property (
    overtemp_status_o && !status2_clear_i && !$past(status2_clear_i) |=> overtemp_status_o)
    else $error("status dropped without clear");
  // no new flag while the pin rests inactive
  a_status_quiet: assert property (
    overtemp_signal_n_i [*8] |-> !$rose(overtemp_status_o))
    else $error("status set with pin inactive");
  // count leaves zero only at two steps
  a_count_first: assert property (
    $changed(cnt) && $past(cnt) == 8'h00 |-> cnt == 8'h02)
    else $error("count left zero at wrong value");
  // count climbs one step at a time or restarts
  a_count_step: assert property (
    $changed(cnt) && $past(cnt) != 8'h00 |-> cnt == $past(cnt) + 8'h01 || cnt == 8'h00)
    else $error("count jumped");
  // low clock enable freezes the timer state
  a_freeze_hold: assert property (
    !clk_en_i |=> $stable(cnt) && $stable(overtemp_status_o))
    else $error("state moved while frozen");
  // locked config fields do not change
  a_lock_holds: assert property (
    config_lock_i [*6] |=> $stable(alert_pin_select_o) && $stable(twowire_input_threshold_o))
    else $error("config changed while locked");
  // main scenarios reached
  c_flag_set: cover property ($rose(overtemp_status_o));
  c_alert_on: cover property ($rose(overtemp_alert_o));
  c_read_done: cover property (rvalid_o);
  c_count_full: cover property (cnt == 8'hFF);
endmodule // thermal_fan_config_registers_monitor

// file: testbench/reg_host_model.sv
// host model issuing register requests on a gated link clock
`timescale 1ns/1ps
module reg_host_model (
  // register clock side
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       rvalid_o,
  input  wire logic [7:0] rdata_o,
  // link side
  output logic            link_clk_o,
  output logic            link_valid_o,
  output logic            link_write_o,
  output logic [7:0]      link_addr_o,
  output logic [7:0]      link_wdata_o
);
  logic busy; // link clock runs only during reset and requests
  initial
  begin
    busy = 1'b0;
    link_clk_o = 1'b0;
    link_valid_o = 1'b0;
    link_write_o = 1'b0;
    link_addr_o = 8'h00;
    link_wdata_o = 8'h00;
  end
  // 6 ns link clock, halted between requests
  always #3 if (busy || !resetn_i) link_clk_o = ~link_clk_o;
  // one request; read data is taken with the answer pulse
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output bit ok);
    int n;
    ok = 1'b1;
    rd = 8'h00;
    busy = 1'b1;
    @(negedge link_clk_o);
    link_valid_o = 1'b1;
    link_write_o = wr;
    link_addr_o = a;
    link_wdata_o = d;
    @(negedge link_clk_o);
    link_valid_o = 1'b0;
    // released lines must not keep the last value
    link_addr_o = ~a;
    link_wdata_o = ~d;
    repeat (2) @(negedge link_clk_o);
    busy = 1'b0;
    if (!wr)
    begin
      ok = 1'b0;
      for (n = 0; n < 20 && !ok; n++)
      begin
        // look between edges, where the registered answer has settled
        @(negedge ref_clk_i);
        if (rvalid_o === 1'b1)
        begin
          ok = 1'b1;
          rd = rdata_o;
        end
      end
    end
    // keeps the minimum request spacing
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
endmodule // reg_host_model

// file: testbench/thermal_fan_config_registers_tb.sv
// self-checking bench for the thermal and fan register bank
`timescale 1ns/1ps
module thermal_fan_config_registers_tb;
  localparam int unsigned STEP = 10; // short timer step
  logic       ref_clk_i = 1'b0;
  logic       resetn_i, clk_en_i, link_clk_i, link_valid_i, link_write_i;
  logic [7:0] link_addr_i, link_wdata_i, rdata_o, overtemp_duration_count_o;
  logic       config_lock_i, fourth_fan_fault_flag_i, status2_clear_i;
  logic       overtemp_signal_n_i, rvalid_o, overtemp_status_o, overtemp_alert_o;
  logic [1:0] tach_pulses_first_o, tach_pulses_second_o;
  logic [1:0] tach_pulses_third_o, tach_pulses_fourth_o, twowire_input_threshold_o;
  logic       alert_pin_select_o;
  int         bad_count = 0;
  int         n_checks = 0;
  // register clock, 100 MHz
  always #5 ref_clk_i = ~ref_clk_i;
  thermal_fan_config_registers #(.STEP_CYCLES(STEP)) u_dut (
    .ref_clk_i, .resetn_i, .clk_en_i, .link_clk_i, .link_valid_i, .link_write_i,
    .link_addr_i, .link_wdata_i, .rdata_o, .rvalid_o, .config_lock_i,
    .fourth_fan_fault_flag_i, .status2_clear_i, .overtemp_signal_n_i,
    .overtemp_status_o, .overtemp_alert_o, .tach_pulses_first_o, .tach_pulses_second_o,
    .tach_pulses_third_o, .tach_pulses_fourth_o, .alert_pin_select_o,
    .twowire_input_threshold_o, .overtemp_duration_count_o);
  reg_host_model u_host (
    .ref_clk_i, .resetn_i, .rvalid_o, .rdata_o, .link_clk_o(link_clk_i),
    .link_valid_o(link_valid_i), .link_write_o(link_write_i),
    .link_addr_o(link_addr_i), .link_wdata_o(link_wdata_i));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    bit         ok;
    u_host.access(1'b1, a, d, v, ok);
  endtask
  // read with a bounded wait for the answer
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    bit         ok;
    u_host.access(1'b0, a, 8'h00, v, ok);
    if (!ok)
    begin
      bad_count++;
      $display("BAD %0t no read answer", $time);
      stop_test();
    end
    else
      check8(v, exp, "read data");
  endtask
  task automatic wait_status(input int bound);
    int n;
    for (n = 0; n < bound && overtemp_status_o !== 1'b1; n++)
      @(negedge ref_clk_i);
    if (n == bound)
    begin
      bad_count++;
      $display("BAD %0t status never set", $time);
      stop_test();
    end
  endtask
  task automatic clear_flag();
    overtemp_signal_n_i = 1'b1;
    status2_clear_i = 1'b1;
    cycles(1);
    status2_clear_i = 1'b0;
    cycles(3);
    check8({7'h00, overtemp_status_o}, 8'h00, "status clear");
  endtask
  task automatic test_reset();
    rd(8'h7A, 8'h00);
    rd(8'h7B, 8'h55);
    rd(8'h7D, 8'h00);
    check8({tach_pulses_fourth_o, tach_pulses_third_o, tach_pulses_second_o,
            tach_pulses_first_o}, 8'h55, "pulse fields");
    $display("test_reset done");
  endtask
  task automatic test_pulses();
    logic [7:0] v[2] = '{8'h1B, 8'hE4};
    foreach (v[i])
    begin
      wr(8'h7B, v[i]);
      rd(8'h7B, v[i]);
      check8({tach_pulses_fourth_o, tach_pulses_third_o, tach_pulses_second_o,
              tach_pulses_first_o}, v[i], "pulse fields");
    end
    $display("test_pulses done");
  endtask
  task automatic test_config();
    logic [1:0] t;
    for (int i = 0; i < 4; i++)
    begin
      t = 2'(i);
      wr(8'h7D, {4'hF, t, 1'b1, t[0]});
      rd(8'h7D, {4'h0, t, 1'b0, t[0]});
      check8({5'h00, twowire_input_threshold_o, alert_pin_select_o},
             {5'h00, t, t[0]}, "config fields");
    end
    config_lock_i = 1'b1;
    cycles(4);
    wr(8'h7D, 8'h00);
    rd(8'h7D, 8'h0D);
    check8({5'h00, twowire_input_threshold_o, alert_pin_select_o}, 8'h07, "locked");
    config_lock_i = 1'b0;
    $display("test_config done");
  endtask
  task automatic test_refused();
    // deliberate writes to test registers, avoided in normal traffic
    wr(8'h7E, 8'hA5);
    wr(8'h7F, 8'h5A);
    wr(8'h7C, 8'hFF);
    rd(8'h7E, 8'h00);
    rd(8'h7F, 8'h00);
    rd(8'h7C, 8'h00);
    $display("test_refused done");
  endtask
  task automatic test_limit_zero();
    wr(8'h7A, 8'h00);
    overtemp_signal_n_i = 1'b0;
    wait_status(8);
    check8(overtemp_duration_count_o, 8'h00, "count");
    cycles(3);
    check8({7'h00, overtemp_alert_o}, 8'h01, "alert");
    fourth_fan_fault_flag_i = 1'b1;
    cycles(6);
    check8({7'h00, overtemp_alert_o}, 8'h00, "masked alert");
    fourth_fan_fault_flag_i = 1'b0;
    wr(8'h7D, 8'h0C);
    check8({7'h00, overtemp_alert_o}, 8'h00, "alert pin deselected");
    wr(8'h7D, 8'h0D);
    check8({7'h00, overtemp_alert_o}, 8'h01, "alert pin reselected");
    clear_flag();
    $display("test_limit_zero done");
  endtask
  task automatic test_limit_steps();
    wr(8'h7A, 8'h03);
    rd(8'h7A, 8'h03);
    overtemp_signal_n_i = 1'b0;
    cycles(15);
    check8(overtemp_duration_count_o, 8'h00, "count below two steps");
    clk_en_i = 1'b0;
    cycles(20);
    clk_en_i = 1'b1;
    wait_status(60);
    check8(overtemp_duration_count_o, 8'h04, "count at flag");
    clear_flag();
    wr(8'h7A, 8'hFF);
    overtemp_signal_n_i = 1'b0;
    cycles(2600);
    check8(overtemp_duration_count_o, 8'hFF, "full count");
    check8({7'h00, overtemp_status_o}, 8'h00, "no flag at top limit");
    overtemp_signal_n_i = 1'b1;
    $display("test_limit_steps done");
  endtask
  initial
  begin
    resetn_i = 1'b0;
    clk_en_i = 1'b1;
    config_lock_i = 1'b0;
    fourth_fan_fault_flag_i = 1'b0;
    status2_clear_i = 1'b0;
    overtemp_signal_n_i = 1'b1;
    cycles(12);
    resetn_i = 1'b1;
    cycles(2);
    test_reset();
    test_pulses();
    test_config();
    test_refused();
    test_limit_zero();
    test_limit_steps();
    stop_test();
  end
endmodule // thermal_fan_config_registers_tb
bind thermal_fan_config_registers thermal_fan_config_registers_monitor #(
  .STEP_CYCLES(STEP_CYCLES)) u_mon (
  .ref_clk_i, .resetn_i, .clk_en_i, .config_lock_i, .fourth_fan_fault_flag_i,
  .status2_clear_i, .overtemp_signal_n_i, .rvalid_o, .overtemp_status_o,
  .overtemp_alert_o, .alert_pin_select_o, .twowire_input_threshold_o,
  .overtemp_duration_count_o);
